// [bench/host_bus_model.sv]
// Behavioural external host on the port pins.
// Assumes active-low strobes, latch strobe and select, as after reset.
`timescale 1ns/10ps
module host_bus_model (
  input  wire        clk,
  input  wire [14:0] pin_o,
  input  wire [14:0] pin_oe,
  output wire [14:0] pin_i
);
  reg [14:0] drv_r    = 15'h0000;
  reg [14:0] drv_en_r = 15'h0000;
  reg        flip_r   = 1'b0;
  // Undriven lines show a changing pattern, not a held value.
  always @(posedge clk) flip_r <= ~flip_r;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ((drv_en_r & drv_r) | (~drv_en_r & {15{flip_r}})));
  task set_pins(input [14:0] en, input [14:0] val);
    begin
      @(posedge clk);
      drv_en_r <= en;
      drv_r    <= val;
    end
  endtask
  // One host access; pins 13 to 8 stay driven afterwards, the data lines are released.
  task xfer(input mux, input dbl, input rd, input [10:0] a, input [7:0] wd, output [7:0] q);
    begin
      @(posedge clk);
      drv_en_r <= {1'b0, 6'h3F, {8{mux | !rd}}};
      drv_r    <= {1'b0, mux & a[10], 1'b1, dbl | rd, mux ? {a[9:8], 1'b0} : a[2:0],
                   mux ? a[7:0] : wd};
      if (mux) begin
        repeat (2) @(posedge clk);
        drv_r[8]       <= 1'b1;
        drv_r[7:0]     <= wd;
        drv_en_r[7:0]  <= {8{!rd}};
      end
      @(posedge clk);
      if (dbl && rd) drv_r[11] <= 1'b0;
      else drv_r[12] <= 1'b0;
      repeat (4) @(posedge clk);
      q = pin_i[7:0];
      drv_r[12:11] <= {1'b1, dbl | rd};
      repeat (3) @(posedge clk);
      drv_en_r[7:0] <= 8'h00;
    end
  endtask
endmodule

// [bench/host_port_pin_mux_asserts.sv]
// Checker of the pin multiplexer, bound onto its top module.
// Assumes the map header and stable register writes through APB.
`timescale 1ns/10ps
`include "host_port_pin_mux_map.vh"
module host_port_pin_mux_asserts (
  input wire                   REF_CLK,
  input wire                   RSTN,
  input wire                   PSEL,
  input wire                   PENABLE,
  input wire                   PWRITE,
  input wire [`HPM_ADDR_W-1:0] PADDR,
  input wire [31:0]            PWDATA,
  input wire [31:0]            PRDATA,
  input wire                   PREADY,
  input wire                   PSLVERR,
  input wire [`HPM_PINS-1:0]   PIN_I,
  input wire [`HPM_PINS-1:0]   PIN_O,
  input wire [`HPM_PINS-1:0]   PIN_OE
);
  reg  [9:0]  ctrl_r;
  reg  [14:0] en_r;
  reg  [14:0] dir_r;
  reg  [14:0] out_r;
  reg  [54:0] cfg1_r;
  reg  [54:0] cfg2_r;
  wire [54:0] cfg     = {ctrl_r, en_r, dir_r, out_r};
  wire        steady  = (cfg == cfg1_r) && (cfg == cfg2_r);
  wire        wr_ok   = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  wire        sel     = ctrl_r[1] | (PIN_I[13] == ctrl_r[6]);
  wire        rd_dbl  = PIN_I[11] == ctrl_r[4];
  wire        rd_sgl  = (PIN_I[12] == ctrl_r[5]) & PIN_I[11];
  wire        rd_live = sel & (ctrl_r[2] ? rd_dbl : rd_sgl);
  wire        lvl     = ctrl_r[9] == ctrl_r[7];
  // Shadow copy of the configuration registers.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r <= 10'h000;
      en_r   <= 15'h0000;
      dir_r  <= 15'h0000;
      out_r  <= 15'h0000;
      cfg1_r <= 55'h0;
      cfg2_r <= 55'h0;
    end else begin
      if (wr_ok && PADDR == 8'h00) ctrl_r <= PWDATA[9:0];
      if (wr_ok && PADDR == 8'h04) dir_r <= PWDATA[14:0];
      if (wr_ok && PADDR == 8'h08) en_r <= PWDATA[14:0];
      if (wr_ok && PADDR == 8'h0C) out_r <= PWDATA[14:0];
      cfg1_r <= cfg;
      cfg2_r <= cfg1_r;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  AST_RESET_QUIET:
    assert property ($rose(RSTN) |-> PIN_OE == 0 && PIN_O == 0) else $error("pins live at reset");
  AST_GPIO_OE:
    assert property (steady && !ctrl_r[0] |-> PIN_OE == (en_r & dir_r)) else $error("gpio enable");
  AST_GPIO_OUT:
    assert property (steady && !ctrl_r[0] |-> (PIN_O & PIN_OE) == (out_r & en_r & dir_r))
      else $error("gpio level");
  AST_DATA_DRIVE:
    assert property (steady && ctrl_r[0] |-> PIN_OE[7:0] == {8{$past(rd_live, 2)}})
      else $error("data bus drive");
  AST_CTRL_PINS_IN:
    assert property (steady && ctrl_r[0] |-> PIN_OE[13:8] == 6'h00) else $error("input driven");
  AST_REQ_PIN:
    assert property (steady && ctrl_r[0] |-> PIN_OE[14] == (!ctrl_r[8] | !lvl)
      && PIN_O[14] == (!ctrl_r[8] & lvl)) else $error("request pin");
  AST_APB_WAIT:
    assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY) else $error("apb wait");
  AST_APB_ERR:
    assert property (PREADY |-> PSLVERR == (PADDR > 8'h1C || PADDR[1:0] != 2'b00))
      else $error("apb error");
endmodule
bind host_port_pin_mux host_port_pin_mux_asserts u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_I(PIN_I), .PIN_O(PIN_O),
  .PIN_OE(PIN_OE));

// [bench/tb_host_port_pin_mux.sv]
// Self-checking bench of the host port pin multiplexer.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb_host_port_pin_mux;
  reg         REF_CLK;
  reg         RSTN;
  reg         PSEL;
  reg         PENABLE;
  reg         PWRITE;
  reg  [7:0]  PADDR;
  reg  [31:0] PWDATA;
  wire [31:0] PRDATA;
  wire        PREADY;
  wire        PSLVERR;
  wire [14:0] PIN_I;
  wire [14:0] PIN_O;
  wire [14:0] PIN_OE;
  integer     mismatches;
  integer     samples_checked;
  integer     i;
  reg  [31:0] d;
  reg         e;
  reg  [7:0]  q;
  host_port_pin_mux u_dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE));
  host_bus_model u_host (.clk(REF_CLK), .pin_o(PIN_O), .pin_oe(PIN_OE), .pin_i(PIN_I));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] wd);
    integer n;
    begin
      @(posedge REF_CLK);
      PSEL    <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= wd;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      n = 0;
      @(posedge REF_CLK);
      while (PREADY !== 1'b1 && n < 16) begin
        @(posedge REF_CLK);
        n = n + 1;
      end
      if (PREADY !== 1'b1) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t no bus answer", $time);
      end
      d = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    apb(1'b1, a, v);
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(d, exp);
    end
  endtask
  task results;
    begin
      if (mismatches == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  initial begin
    repeat (5000) @(posedge REF_CLK);
    mismatches = mismatches + 1;
    results;
  end
  initial begin
    RSTN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge REF_CLK);
    RSTN <= 1'b1;
    check(PIN_OE, 32'h0);
    for (i = 0; i < 20; i = i + 4) rdc(i[7:0], 32'h0);
    rdc(8'h1C, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(e, 1'b1);
    check(d, 32'h0);
    apb(1'b1, 8'h06, 32'h1);
    check(e, 1'b1);
    wr(8'h08, 32'h3F7F);
    wr(8'h04, 32'h00FF);
    wr(8'h0C, 32'h00A5);
    u_host.set_pins(15'h7F00, 15'h5A00);
    repeat (3) @(posedge REF_CLK);
    check({PIN_OE, PIN_O & PIN_OE}, {15'h007F, 15'h0025});
    rdc(8'h10, 32'h1A25);
    wr(8'h18, 32'h3C);
    wr(8'h00, 32'h1);
    u_host.xfer(1'b0, 1'b0, 1'b1, 11'h005, 8'h00, q);
    check(q, 8'h3C);
    apb(1'b0, 8'h14, 32'h0);
    check(d[2:0], 3'h5);
    u_host.xfer(1'b0, 1'b0, 1'b0, 11'h003, 8'hC3, q);
    rdc(8'h1C, 32'hC3);
    apb(1'b0, 8'h14, 32'h0);
    check(d[15], 1'b1);
    wr(8'h14, 32'h8000);
    apb(1'b0, 8'h14, 32'h0);
    check(d[15], 1'b0);
    wr(8'h18, 32'h96);
    wr(8'h00, 32'h5);
    u_host.xfer(1'b0, 1'b1, 1'b1, 11'h000, 8'h00, q);
    check(q, 8'h96);
    u_host.xfer(1'b0, 1'b1, 1'b0, 11'h000, 8'h69, q);
    rdc(8'h1C, 32'h69);
    wr(8'h00, 32'h3);
    u_host.xfer(1'b1, 1'b0, 1'b0, 11'h5A7, 8'h1E, q);
    apb(1'b0, 8'h14, 32'h0);
    check(d[10:0], 11'h5A7);
    rdc(8'h1C, 32'h1E);
    u_host.xfer(1'b1, 1'b0, 1'b1, 11'h0F0, 8'h00, q);
    check(q, 8'h96);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h00, 32'h1 | (i << 7));
      repeat (2) @(posedge REF_CLK);
      check({PIN_OE[14], PIN_O[14]}, i[1] ? {i[2] != i[0], 1'b0} : {1'b1, i[2] == i[0]});
    end
    wr(8'h00, 32'h0);
    repeat (3) @(posedge REF_CLK);
    RSTN <= 1'b0;
    @(posedge REF_CLK);
    check(PIN_OE, 32'h0);
    RSTN <= 1'b1;
    rdc(8'h08, 32'h0);
    results;
  end
endmodule

// [hw/gpio_pin_bank.v]
// General-purpose view of the port pins: per pin connected or not, and input or output.
// Assumes sampled pin levels; the top registers the outputs before they leave the block.
`timescale 1ns/10ps
`include "host_port_pin_mux_map.vh"

module gpio_pin_bank (
  input  wire [`HPM_PINS-1:0] en,
  input  wire [`HPM_PINS-1:0] dir,
  input  wire [`HPM_PINS-1:0] out,
  input  wire [`HPM_PINS-1:0] pins,
  output reg  [`HPM_PINS-1:0] oe,
  output reg  [`HPM_PINS-1:0] o,
  output reg  [`HPM_PINS-1:0] seen
);

  integer i;

  always @* begin
    oe   = {`HPM_PINS{1'b0}};
    o    = {`HPM_PINS{1'b0}};
    seen = {`HPM_PINS{1'b0}};
    for (i = 0; i < `HPM_PINS; i = i + 1) begin
      // A disconnected pin neither drives nor shows its level.
      if (en[i]) begin
        oe[i]   = dir[i];
        o[i]    = dir[i] & out[i];
        seen[i] = dir[i] ? out[i] : pins[i];
      end
    end
  end

endmodule

// [hw/host_port_pin_mux.v]
// Top of the host port pin multiplexer with its APB register file.
// Assumes pin inputs synchronous to REF_CLK and an outside resolver for the pin enables.
`timescale 1ns/10ps
`include "host_port_pin_mux_map.vh"

module host_port_pin_mux (
  input  wire                   REF_CLK,
  input  wire                   RSTN,
  input  wire                   PSEL,
  input  wire                   PENABLE,
  input  wire                   PWRITE,
  input  wire [`HPM_ADDR_W-1:0] PADDR,
  input  wire [31:0]            PWDATA,
  output wire [31:0]            PRDATA,
  output wire                   PREADY,
  output wire                   PSLVERR,
  input  wire [`HPM_PINS-1:0]   PIN_I,
  output wire [`HPM_PINS-1:0]   PIN_O,
  output wire [`HPM_PINS-1:0]   PIN_OE
);

  reg  [`HPM_CTRL_W-1:0] ctrl_r;
  reg  [`HPM_PINS-1:0]   dir_r;
  reg  [`HPM_PINS-1:0]   en_r;
  reg  [`HPM_PINS-1:0]   out_r;
  reg  [7:0]             rdata_r;
  reg  [7:0]             wdata_r;
  reg                    wflag_r;
  reg  [10:0]            addr_r;
  reg                    wr_prev_r;
  reg  [`HPM_PINS-1:0]   pin_q_r;
  reg  [31:0]            prdata_r;
  reg                    pready_r;
  reg                    pslverr_r;
  reg  [`HPM_PINS-1:0]   pin_o_r;
  reg  [`HPM_PINS-1:0]   pin_oe_r;

  reg  [31:0]            prdata_nxt;
  reg                    pslverr_nxt;
  reg  [`HPM_PINS-1:0]   pin_o_nxt;
  reg  [`HPM_PINS-1:0]   pin_oe_nxt;
  reg                    req_level;

  wire                   host_fn;
  wire                   rd_act;
  wire                   wr_act;
  wire                   sel_act;
  wire                   ale_act;
  wire [10:0]            addr_live;
  wire [`HPM_PINS-1:0]   gp_oe;
  wire [`HPM_PINS-1:0]   gp_o;
  wire [`HPM_PINS-1:0]   gp_seen;
  wire                   access;
  wire                   commit;
  wire                   do_write;
  wire                   wflag_clr;
  wire                   wflag_set;
  wire [15:0]            stat;

  assign host_fn = ctrl_r[`HPM_CTRL_HOST];

  host_strobe_decode u_decode (
    .pins      (pin_q_r),
    .mux_mode  (ctrl_r[`HPM_CTRL_MUX]),
    .dbl_mode  (ctrl_r[`HPM_CTRL_DBL]),
    .ale_pol   (ctrl_r[`HPM_CTRL_ALE_POL]),
    .rd_pol    (ctrl_r[`HPM_CTRL_RD_POL]),
    .ds_pol    (ctrl_r[`HPM_CTRL_DS_POL]),
    .cs_pol    (ctrl_r[`HPM_CTRL_CS_POL]),
    .rd_act    (rd_act),
    .wr_act    (wr_act),
    .sel_act   (sel_act),
    .ale_act   (ale_act),
    .addr_live (addr_live)
  );

  gpio_pin_bank u_gpio (
    .en   (en_r),
    .dir  (dir_r),
    .out  (out_r),
    .pins (pin_q_r),
    .oe   (gp_oe),
    .o    (gp_o),
    .seen (gp_seen)
  );

  // APB access phase takes one wait state; the write commits with PREADY high.
  assign access   = PSEL & PENABLE & ~pready_r;
  assign commit   = PSEL & PENABLE & pready_r;
  assign do_write = commit & PWRITE & ~pslverr_r;

  assign wflag_clr = do_write & (PADDR == `HPM_OFF_STAT) & PWDATA[`HPM_STAT_WFLAG];
  assign wflag_set = host_fn & wr_prev_r & ~wr_act;

  assign stat = {wflag_r, sel_act & host_fn, wr_act & host_fn, rd_act & host_fn,
                 ale_act & host_fn, addr_r};

  // Read data and error answer are formed in the first access cycle.
  always @* begin
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (PADDR == `HPM_OFF_CTRL) begin
      prdata_nxt = {22'h00_0000, ctrl_r};
    end else if (PADDR == `HPM_OFF_DIR) begin
      prdata_nxt = {17'h0_0000, dir_r};
    end else if (PADDR == `HPM_OFF_EN) begin
      prdata_nxt = {17'h0_0000, en_r};
    end else if (PADDR == `HPM_OFF_OUT) begin
      prdata_nxt = {17'h0_0000, out_r};
    end else if (PADDR == `HPM_OFF_IN) begin
      prdata_nxt = {17'h0_0000, host_fn ? {`HPM_PINS{1'b0}} : gp_seen};
    end else if (PADDR == `HPM_OFF_STAT) begin
      prdata_nxt = {16'h0000, stat};
    end else if (PADDR == `HPM_OFF_RDATA) begin
      prdata_nxt = {24'h00_0000, rdata_r};
    end else if (PADDR == `HPM_OFF_WDATA) begin
      prdata_nxt = {24'h00_0000, wdata_r};
    end else begin
      pslverr_nxt = 1'b1;
    end
    if (PWRITE) begin
      prdata_nxt = 32'h0000_0000;
    end
  end

  // Host request level: asserted means low unless the polarity bit is set.
  always @* begin
    req_level = ctrl_r[`HPM_CTRL_REQ] ^ ~ctrl_r[`HPM_CTRL_REQ_POL];
  end

  // Pin drive plan for the next cycle.
  always @* begin
    pin_o_nxt  = {`HPM_PINS{1'b0}};
    pin_oe_nxt = {`HPM_PINS{1'b0}};
    if (host_fn) begin
      if (rd_act) begin
        pin_oe_nxt[`HPM_PIN_DATA_HI:`HPM_PIN_DATA_LO] = 8'hFF;
        pin_o_nxt[`HPM_PIN_DATA_HI:`HPM_PIN_DATA_LO]  = rdata_r;
      end
      pin_o_nxt[`HPM_PIN_REQ] = req_level;
      if (ctrl_r[`HPM_CTRL_REQ_OD]) begin
        pin_oe_nxt[`HPM_PIN_REQ] = ~req_level;
        pin_o_nxt[`HPM_PIN_REQ]  = 1'b0;
      end else begin
        pin_oe_nxt[`HPM_PIN_REQ] = 1'b1;
      end
    end else begin
      pin_oe_nxt = gp_oe;
      pin_o_nxt  = gp_o;
    end
  end

  // Register file and APB answer.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_r    <= `HPM_CTRL_RST;
      dir_r     <= {`HPM_PINS{1'b0}};
      en_r      <= {`HPM_PINS{1'b0}};
      out_r     <= {`HPM_PINS{1'b0}};
      rdata_r   <= 8'h00;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access;
      if (access) begin
        prdata_r  <= prdata_nxt;
        pslverr_r <= pslverr_nxt;
      end else if (commit) begin
        prdata_r  <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
      if (do_write) begin
        if (PADDR == `HPM_OFF_CTRL) begin
          ctrl_r <= PWDATA[`HPM_CTRL_W-1:0];
        end else if (PADDR == `HPM_OFF_DIR) begin
          dir_r <= PWDATA[`HPM_PINS-1:0];
        end else if (PADDR == `HPM_OFF_EN) begin
          en_r <= PWDATA[`HPM_PINS-1:0];
        end else if (PADDR == `HPM_OFF_OUT) begin
          out_r <= PWDATA[`HPM_PINS-1:0];
        end else if (PADDR == `HPM_OFF_RDATA) begin
          rdata_r <= PWDATA[7:0];
        end
      end
    end
  end

  // Host side capture: address latch, write data and the sticky write flag.
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_q_r   <= {`HPM_PINS{1'b0}};
      addr_r    <= 11'h000;
      wdata_r   <= 8'h00;
      wflag_r   <= 1'b0;
      wr_prev_r <= 1'b0;
      pin_o_r   <= {`HPM_PINS{1'b0}};
      pin_oe_r  <= {`HPM_PINS{1'b0}};
    end else begin
      pin_q_r   <= PIN_I;
      pin_o_r   <= pin_o_nxt;
      pin_oe_r  <= pin_oe_nxt;
      wr_prev_r <= host_fn & wr_act;
      if (host_fn) begin
        if (ctrl_r[`HPM_CTRL_MUX]) begin
          if (ale_act) begin
            addr_r <= addr_live;
          end else begin
            addr_r[10:8] <= addr_live[10:8];
          end
        end else begin
          addr_r <= addr_live;
        end
        if (wr_act) begin
          wdata_r <= pin_q_r[`HPM_PIN_DATA_HI:`HPM_PIN_DATA_LO];
        end
      end
      if (wflag_set) begin
        wflag_r <= 1'b1;
      end else if (wflag_clr) begin
        wflag_r <= 1'b0;
      end
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  assign PIN_O   = pin_o_r;
  assign PIN_OE  = pin_oe_r;

endmodule

// [hw/host_port_pin_mux_map.vh]
// Register offsets, field positions and reset values of the host port pin multiplexer.
// Assumes a 32-bit APB with byte addresses; every register takes one aligned word.
`ifndef HOST_PORT_PIN_MUX_MAP_VH
`define HOST_PORT_PIN_MUX_MAP_VH

`define HPM_PINS         15
`define HPM_ADDR_W       8

`define HPM_OFF_CTRL     8'h00
`define HPM_OFF_DIR      8'h04
`define HPM_OFF_EN       8'h08
`define HPM_OFF_OUT      8'h0C
`define HPM_OFF_IN       8'h10
`define HPM_OFF_STAT     8'h14
`define HPM_OFF_RDATA    8'h18
`define HPM_OFF_WDATA    8'h1C

`define HPM_CTRL_W       10
`define HPM_CTRL_HOST    0
`define HPM_CTRL_MUX     1
`define HPM_CTRL_DBL     2
`define HPM_CTRL_ALE_POL 3
`define HPM_CTRL_RD_POL  4
`define HPM_CTRL_DS_POL  5
`define HPM_CTRL_CS_POL  6
`define HPM_CTRL_REQ_POL 7
`define HPM_CTRL_REQ_OD  8
`define HPM_CTRL_REQ     9
`define HPM_CTRL_RST     10'h000

`define HPM_STAT_ADDR_LO 0
`define HPM_STAT_ADDR_HI 10
`define HPM_STAT_ALE     11
`define HPM_STAT_RD      12
`define HPM_STAT_WR      13
`define HPM_STAT_SEL     14
`define HPM_STAT_WFLAG   15

`define HPM_PIN_DATA_LO  0
`define HPM_PIN_DATA_HI  7
`define HPM_PIN_A0       8
`define HPM_PIN_A1       9
`define HPM_PIN_A2       10
`define HPM_PIN_RW       11
`define HPM_PIN_DS       12
`define HPM_PIN_CS       13
`define HPM_PIN_REQ      14

`endif

// [hw/host_strobe_decode.v]
// Decodes the sampled host port pins into address, strobe and select levels.
// Assumes sampled pin levels and the control bits from the register file.
`timescale 1ns/10ps
`include "host_port_pin_mux_map.vh"

module host_strobe_decode (
  input  wire [`HPM_PINS-1:0] pins,
  input  wire                 mux_mode,
  input  wire                 dbl_mode,
  input  wire                 ale_pol,
  input  wire                 rd_pol,
  input  wire                 ds_pol,
  input  wire                 cs_pol,
  output reg                  rd_act,
  output reg                  wr_act,
  output reg                  sel_act,
  output reg                  ale_act,
  output reg  [10:0]          addr_live
);

  // A pin counts as asserted when its level matches the polarity bit (1 means active high).
  function active;
    input level;
    input pol;
    begin
      active = pol ? level : ~level;
    end
  endfunction

  reg strobe;

  always @* begin
    strobe  = 1'b0;
    rd_act  = 1'b0;
    wr_act  = 1'b0;
    sel_act = 1'b1;
    ale_act = 1'b0;
    addr_live = 11'h000;
    if (mux_mode) begin
      ale_act   = active(pins[`HPM_PIN_A0], ale_pol);
      addr_live = {pins[`HPM_PIN_CS], pins[`HPM_PIN_A2], pins[`HPM_PIN_A1],
                   pins[`HPM_PIN_DATA_HI:`HPM_PIN_DATA_LO]};
    end else begin
      sel_act   = active(pins[`HPM_PIN_CS], cs_pol);
      addr_live = {8'h00, pins[`HPM_PIN_A2], pins[`HPM_PIN_A1], pins[`HPM_PIN_A0]};
    end
    if (dbl_mode) begin
      rd_act = sel_act & active(pins[`HPM_PIN_RW], rd_pol);
      wr_act = sel_act & active(pins[`HPM_PIN_DS], ds_pol);
    end else begin
      strobe = sel_act & active(pins[`HPM_PIN_DS], ds_pol);
      rd_act = strobe & pins[`HPM_PIN_RW];
      wr_act = strobe & ~pins[`HPM_PIN_RW];
    end
  end

endmodule
